//--- hdl/srw_consts.svh
`ifndef SRW_CONSTS_SVH
`define SRW_CONSTS_SVH

// Clock period in picoseconds
`define SRW_CLK_PERIOD_PS 64'd10000
// Timeouts in milliseconds, as specified
`define SRW_RESET_TIMEOUT_MS 64'd140
`define SRW_WD_LONG_MS 64'd35000
`define SRW_WD_SHORT_MS 64'd1120
// Least times round up to whole cycles
`define SRW_MS_TO_CYC(ms) (((ms) * 64'd1000000000 + `SRW_CLK_PERIOD_PS - 64'd1) / `SRW_CLK_PERIOD_PS)
`define SRW_RESET_TIMEOUT_CYC `SRW_MS_TO_CYC(`SRW_RESET_TIMEOUT_MS)
`define SRW_WD_LONG_CYC `SRW_MS_TO_CYC(`SRW_WD_LONG_MS)
`define SRW_WD_SHORT_CYC `SRW_MS_TO_CYC(`SRW_WD_SHORT_MS)
// Synchroniser reset values: undervoltage inactive, manual reset released
`define SRW_SYNC_RST 6'h00

`endif

//--- hdl/srw_pkg.sv
package srw_pkg;

  // Synchronised pin levels, all active high meaning "fault present" except kick
  typedef struct packed {
    logic uv_primary;
    logic uv_secondary;
    logic uv_aux;
    logic pf_low;
    logic manual_low;
    logic kick;
  } srw_causes_t;

  // Watchdog mode
  typedef enum logic [0:0] {
    SRW_WD_LONG  = 1'b0,
    SRW_WD_SHORT = 1'b1
  } srw_wd_mode_t;

endpackage

//--- hdl/srw_supervisor.sv
`timescale 1ns/1ps
`include "srw_consts.svh"

module srw_supervisor #(
  parameter logic [35:0] RESET_TIMEOUT_CYC = 36'(`SRW_RESET_TIMEOUT_CYC),
  parameter logic [35:0] WD_LONG_CYC       = 36'(`SRW_WD_LONG_CYC),
  parameter logic [35:0] WD_SHORT_CYC      = 36'(`SRW_WD_SHORT_CYC)
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Comparator results, high while input is below its threshold
  input  wire logic i_primary_supply_low,
  input  wire logic i_secondary_supply_low,
  input  wire logic i_aux_undervoltage_in,
  input  wire logic i_power_fail_in,
  // Processor-side pins
  input  wire logic i_manual_reset_n,
  input  wire logic i_watchdog_kick,
  // Outputs
  output logic      o_primary_reset_n,
  output logic      o_secondary_reset_n,
  output logic      o_power_fail_out_n,
  output logic      o_wd_short_mode
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [5:0]          sync_a;
  logic [5:0]          sync_b;
  srw_pkg::srw_causes_t cause;
  logic                kick_prev;

  // Two flops on every pin; first stage read only by second
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync_a <= `SRW_SYNC_RST;
      sync_b <= `SRW_SYNC_RST;
    end else begin
      sync_a <= {i_primary_supply_low, i_secondary_supply_low, i_aux_undervoltage_in,
                 i_power_fail_in, ~i_manual_reset_n, i_watchdog_kick};
      sync_b <= sync_a;
    end
  end

  // Second stage carries the pin order of the struct, so one cast maps it
  assign cause = srw_pkg::srw_causes_t'(sync_b);

  // ****************************************************************
  // Cause decoding
  // ****************************************************************
  logic                sec_cause;
  logic                pri_cause;
  logic                kick_edge;
  logic                wd_expire;

  // Secondary output ignores the auxiliary input and the watchdog
  assign sec_cause = cause.uv_primary | cause.uv_secondary | cause.manual_low;

  // Primary output sees every cause except power fail, the watchdog included
  assign pri_cause = sec_cause | cause.uv_aux | wd_expire;

  // Either direction of the kick counts as a valid transition
  assign kick_edge = cause.kick ^ kick_prev;

  // Edge detector starts at the idle kick level, so no false edge after reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      kick_prev <= 1'b0;
    end else begin
      kick_prev <= cause.kick;
    end
  end

  // ****************************************************************
  // Secondary reset timer
  // ****************************************************************
  localparam logic [35:0] RESET_LAST = RESET_TIMEOUT_CYC - 36'h1;

  logic [35:0]         sec_cnt;

  // Output held low while a cause stands, then for one full timeout
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_secondary_reset_n <= 1'b0;
      sec_cnt             <= 36'h0;
    end else if (sec_cause) begin
      o_secondary_reset_n <= 1'b0;
      sec_cnt             <= 36'h0;
    end else if (!o_secondary_reset_n) begin
      if (sec_cnt == RESET_LAST) begin
        o_secondary_reset_n <= 1'b1;
        sec_cnt             <= 36'h0;
      end else begin
        sec_cnt <= sec_cnt + 36'h1;
      end
    end
  end

  // ****************************************************************
  // Primary reset timer
  // ****************************************************************
  logic [35:0]         pri_cnt;

  // Same timer as the secondary, with more causes feeding it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_primary_reset_n <= 1'b0;
      pri_cnt           <= 36'h0;
    end else if (pri_cause) begin
      o_primary_reset_n <= 1'b0;
      pri_cnt           <= 36'h0;
    end else if (!o_primary_reset_n) begin
      if (pri_cnt == RESET_LAST) begin
        o_primary_reset_n <= 1'b1;
        pri_cnt           <= 36'h0;
      end else begin
        pri_cnt <= pri_cnt + 36'h1;
      end
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  localparam logic [35:0] WD_LONG_LAST  = WD_LONG_CYC - 36'h1;
  localparam logic [35:0] WD_SHORT_LAST = WD_SHORT_CYC - 36'h1;

  srw_pkg::srw_wd_mode_t wd_mode;
  logic [35:0]           wd_cnt;
  logic [35:0]           wd_last;

  // Limit follows the mode; a mode change takes effect at once
  assign wd_last = (wd_mode == srw_pkg::SRW_WD_SHORT) ? WD_SHORT_LAST : WD_LONG_LAST;

  // Every reset event falls back to the long boot period
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wd_mode <= srw_pkg::SRW_WD_LONG;
    end else if (!o_primary_reset_n) begin
      wd_mode <= srw_pkg::SRW_WD_LONG;
    end else if (kick_edge) begin
      wd_mode <= srw_pkg::SRW_WD_SHORT;
    end
  end

  // Counter cleared in reset and by any kick; expiry is a one-cycle pulse
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wd_cnt    <= 36'h0;
      wd_expire <= 1'b0;
    end else if (!o_primary_reset_n || kick_edge) begin
      wd_cnt    <= 36'h0;
      wd_expire <= 1'b0;
    end else if (wd_cnt == wd_last) begin
      wd_cnt    <= 36'h0;
      wd_expire <= 1'b1;
    end else begin
      wd_cnt    <= wd_cnt + 36'h1;
      wd_expire <= 1'b0;
    end
  end

  // Mode is already a flop, so the status output copies it directly
  assign o_wd_short_mode = wd_mode[0];

  // ****************************************************************
  // Power-fail output
  // ****************************************************************
  // No timeout here: the output tracks the comparator, released at once
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_power_fail_out_n <= 1'b1;
    end else begin
      o_power_fail_out_n <= ~cause.pf_low;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Secondary output goes low one cycle after its cause
  property p_sec_follow;
    @(posedge i_clk) disable iff (i_sys_rst)
      sec_cause |=> !o_secondary_reset_n;
  endproperty
  a_sec_follow: assert property (p_sec_follow) else $error("secondary reset missed its cause");

  // Secondary release only after a complete timeout
  property p_sec_release;
    @(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_secondary_reset_n) |-> $past(sec_cnt) == RESET_LAST;
  endproperty
  a_sec_release: assert property (p_sec_release) else $error("secondary reset released early");

  // Manual reset low drives the primary output low
  property p_pri_manual;
    @(posedge i_clk) disable iff (i_sys_rst)
      cause.manual_low |=> !o_primary_reset_n;
  endproperty
  a_pri_manual: assert property (p_pri_manual) else $error("manual reset ignored");

  // Auxiliary undervoltage drives the primary output low
  property p_pri_aux;
    @(posedge i_clk) disable iff (i_sys_rst)
      cause.uv_aux |=> !o_primary_reset_n;
  endproperty
  a_pri_aux: assert property (p_pri_aux) else $error("aux undervoltage ignored");

  // Watchdog expiry drives the primary output low
  property p_wd_expire;
    @(posedge i_clk) disable iff (i_sys_rst)
      wd_expire |=> !o_primary_reset_n;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry ignored");

  // A kick edge clears the watchdog count
  property p_wd_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      kick_edge |=> wd_cnt == 36'h0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("kick did not clear watchdog");

  // Reset puts the watchdog back in long mode
  property p_wd_long;
    @(posedge i_clk) disable iff (i_sys_rst)
      !o_primary_reset_n |=> wd_mode == srw_pkg::SRW_WD_LONG;
  endproperty
  a_wd_long: assert property (p_wd_long) else $error("watchdog not in long mode after reset");

  // Renewed cause restarts the timeout count
  property p_restart;
    @(posedge i_clk) disable iff (i_sys_rst)
      pri_cause |=> pri_cnt == 36'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("timeout not restarted");

  // Power-fail output follows its comparator with no timeout
  property p_pf_follow;
    @(posedge i_clk) disable iff (i_sys_rst)
      1'b1 |=> o_power_fail_out_n == !$past(cause.pf_low);
  endproperty
  a_pf_follow: assert property (p_pf_follow) else $error("power-fail output wrong");

endmodule

//--- sim/srw_cpu_model.sv
`timescale 1ns/1ps
module srw_cpu_model (
  // Clock and kick enable
  input  wire logic i_clk,
  input  wire logic i_en,
  // Watchdog kick toward the supervisor
  output logic      o_kick = 1'b0
);
  // Toggle well inside the short period; disabling lets it stall
  always_ff @(negedge i_clk) if (i_en) o_kick <= ~o_kick;
endmodule

//--- sim/supervisor_reset_watchdog_bench.sv
`timescale 1ns/1ps
module supervisor_reset_watchdog_bench;
  logic clk = 1'b0, rst = 1'b1, mr_n = 1'b1, power_fail_in = 1'b0, en = 1'b0, kick, pr_n, sr_n, pf_n, wdm;
  logic uv1 = 1'b0, uv2 = 1'b0, aux = 1'b0;
  logic [15:0] lfsr = 16'h2903;
  int miscompares = 0, compares = 0, cyc = 0, low = 0;
  // Short timeouts keep the run brief
  srw_supervisor #(.RESET_TIMEOUT_CYC(36'h8), .WD_LONG_CYC(36'h28), .WD_SHORT_CYC(36'hC)) srw_supervisor_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_primary_supply_low(uv1), .i_secondary_supply_low(uv2),
    .i_aux_undervoltage_in(aux), .i_power_fail_in(power_fail_in), .i_manual_reset_n(mr_n), .i_watchdog_kick(kick),
    .o_primary_reset_n(pr_n), .o_secondary_reset_n(sr_n), .o_power_fail_out_n(pf_n), .o_wd_short_mode(wdm));
  srw_cpu_model srw_cpu_model_inst (.i_clk(clk), .i_en(en), .o_kick(kick));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic s, input logic e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %0t seen %b", $time, s);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) if (++cyc > 3000) begin
    miscompares++;
    end_sim;
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    en = 1'b1;
    repeat (20) @(negedge clk);
    mr_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(pr_n, 1'b0);
    chk(sr_n, 1'b0);
    mr_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(pr_n, 1'b0);
    chk(sr_n, 1'b0);
    repeat (14) @(negedge clk);
    chk(pr_n, 1'b1);
    chk(sr_n, 1'b1);
    $display("manual reset test done");
    aux = 1'b1;
    repeat (5) @(negedge clk);
    chk(pr_n, 1'b0);
    chk(sr_n, 1'b1);
    aux = 1'b0;
    repeat (14) @(negedge clk);
    chk(pr_n, 1'b1);
    uv2 = 1'b1;
    repeat (5) @(negedge clk);
    chk(sr_n, 1'b0);
    chk(pr_n, 1'b0);
    uv2 = 1'b0;
    repeat (6) @(negedge clk);
    uv1 = 1'b1;
    @(negedge clk);
    uv1 = 1'b0;
    repeat (8) @(negedge clk);
    chk(sr_n, 1'b0);
    chk(pr_n, 1'b0);
    repeat (6) @(negedge clk);
    chk(sr_n, 1'b1);
    chk(pr_n, 1'b1);
    $display("undervoltage test done");
    for (int i = 0; i < 40; i++) begin
      lfsr = nxt(lfsr);
      power_fail_in = lfsr[0];
      repeat (5) @(negedge clk);
      chk(pf_n, ~power_fail_in);
    end
    $display("power fail test done");
    chk(wdm, 1'b1);
    en = 1'b0;
    repeat (70) @(negedge clk) low += int'(pr_n === 1'b0);
    chk(low != 0, 1'b1);
    chk(wdm, 1'b0);
    chk(sr_n, 1'b1);
    $display("watchdog test done");
    end_sim;
  end
endmodule
